// *** rtl/anim_seq_pkg.sv ***
/*
 * Constants for the LED matrix animation sequencer: register map, field
 * layout, reset values, timing figures and the playback state type.
 * Assumes a 10 MHz core clock and an 8-bit register write/read port.
 */
`default_nettype none
package anim_seq_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ANIMATION_MODE_ADDR = 8'h02;
    localparam logic [7:0] FRAME_TIMING_SCROLL_ADDR = 8'h03;
    localparam logic [7:0] DISPLAY_OPTIONS_ADDR = 8'h04;
    localparam logic [7:0] ANIMATION_MODE_RST = 8'h00;
    localparam logic [7:0] FRAME_TIMING_SCROLL_RST = 8'h00;
    localparam logic [7:0] DISPLAY_OPTIONS_RST = 8'h20;

    // ==========================================================
    // Field positions
    localparam int BLINK_OFF_BIT = 7;
    localparam int END_LAST_BIT = 6;
    localparam int LEN_MSB = 5;
    localparam int FADE_BIT = 7;
    localparam int DIR_BIT = 6;
    localparam int BLOCK_BIT = 5;
    localparam int SCROLL_BIT = 4;
    localparam int IVL_MSB = 3;
    localparam int LOOPS_MSB = 7;
    localparam int LOOPS_LSB = 5;
    localparam int BLINK_PER_BIT = 4;
    localparam int LIMIT_MSB = 3;

    localparam logic [2:0] LOOPS_ENDLESS = 3'h7;
    localparam logic [2:0] LOOPS_INVALID = 3'h0;
    localparam logic [5:0] MAX_FRAME_LEN = 6'h23;
    localparam logic [3:0] LAST_LINE = 4'hB;
    localparam int LINE_COUNT = 12;

    // ==========================================================
    // Timing
    localparam longint CLK_HZ = 10000000;
    localparam longint FRAME_UNIT_US = 32500;
    localparam longint FRAME_UNIT_CYC = FRAME_UNIT_US * CLK_HZ / 1000000;
    localparam longint BLINK_SHORT_MS = 1500;
    localparam longint BLINK_LONG_MS = 3000;
    localparam longint BLINK_SHORT_HALF_CYC = BLINK_SHORT_MS * CLK_HZ / 2000;
    localparam longint BLINK_LONG_HALF_CYC = BLINK_LONG_MS * CLK_HZ / 2000;
    localparam longint REFRESH_HZ = 430;
    localparam longint LINE_CYC = CLK_HZ / (REFRESH_HZ * LINE_COUNT);

    localparam int TICK_W = 19;
    localparam int BLINK_W = 25;
    localparam int LINE_CNT_W = 11;

    // ==========================================================
    // Playback state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STILL = 2'b01,
        ST_PLAY = 2'b10,
        ST_HALT = 2'b11
    } play_state_t;
endpackage
`default_nettype wire

// *** rtl/led_matrix_animation_sequencer.sv ***
/*
 * Playback and scan control for a 12-line LED matrix: frame stepping,
 * loops, scroll and fade flags, global blink and the scan limit.
 * Assumes an upstream serial decoder delivering register writes and
 * reads as one-cycle strobes, plus the run/still requests and start frame.
 */
`timescale 1ns/1ps
`default_nettype none
module led_matrix_animation_sequencer #(
    parameter longint FRAME_UNIT_CYCLES = anim_seq_pkg::FRAME_UNIT_CYC,
    parameter longint BLINK_SHORT_HALF = anim_seq_pkg::BLINK_SHORT_HALF_CYC,
    parameter longint BLINK_LONG_HALF = anim_seq_pkg::BLINK_LONG_HALF_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Requests from the picture and animation controls
    input wire logic run_req,
    input wire logic still_req,
    input wire logic [5:0] start_frame,
    input wire logic [5:0] still_frame,
    // Display control
    output logic [3:0] current_sink_line,
    output logic [5:0] frame_index,
    output logic frame_step,
    output logic playing,
    output logic showing,
    output logic blink_on,
    output logic blink_allowed,
    output logic fade_active,
    output logic scroll_active,
    output logic scroll_left,
    output logic scroll_block
);
    import anim_seq_pkg::*;

    // ==========================================================
    // Registers
    logic [7:0] mode_ff, nxt_mode;
    logic [7:0] timing_ff, nxt_timing;
    logic [7:0] option_ff, nxt_option;
    logic [7:0] rdata_ff, nxt_rdata;
    always_comb begin
        nxt_mode = mode_ff;
        nxt_timing = timing_ff;
        nxt_option = option_ff;
        nxt_rdata = rdata_ff;
        if (reg_wr) begin
            case (reg_addr)
                ANIMATION_MODE_ADDR: nxt_mode = reg_wdata;
                FRAME_TIMING_SCROLL_ADDR: nxt_timing = reg_wdata;
                DISPLAY_OPTIONS_ADDR: nxt_option = reg_wdata;
                default: nxt_mode = mode_ff;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ANIMATION_MODE_ADDR: nxt_rdata = mode_ff;
                FRAME_TIMING_SCROLL_ADDR: nxt_rdata = timing_ff;
                DISPLAY_OPTIONS_ADDR: nxt_rdata = option_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mode_ff <= ANIMATION_MODE_RST;
            timing_ff <= FRAME_TIMING_SCROLL_RST;
            option_ff <= DISPLAY_OPTIONS_RST;
            rdata_ff <= 8'h00;
        end else begin
            mode_ff <= nxt_mode;
            timing_ff <= nxt_timing;
            option_ff <= nxt_option;
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // Field decode
    logic [5:0] len_f;
    logic [3:0] ivl_f;
    logic [2:0] loops_f;
    logic [3:0] limit_f;
    logic scroll_en;
    assign len_f = (mode_ff[LEN_MSB:0] > MAX_FRAME_LEN) ? MAX_FRAME_LEN : mode_ff[LEN_MSB:0];
    assign ivl_f = timing_ff[IVL_MSB:0];
    assign loops_f = option_ff[LOOPS_MSB:LOOPS_LSB];
    assign limit_f = (option_ff[LIMIT_MSB:0] > LAST_LINE) ? LAST_LINE : option_ff[LIMIT_MSB:0];
    assign scroll_en = timing_ff[SCROLL_BIT];

    // ==========================================================
    // Scan of current sink lines
    logic [LINE_CNT_W-1:0] line_cnt_ff, nxt_line_cnt;
    logic [3:0] line_ff, nxt_line;
    logic scan_wrap;
    always_comb begin
        nxt_line_cnt = line_cnt_ff + 1'b1;
        nxt_line = line_ff;
        scan_wrap = 1'b0;
        if (line_cnt_ff == LINE_CNT_W'(LINE_CYC - 1)) begin
            nxt_line_cnt = '0;
            if (line_ff >= limit_f) begin
                nxt_line = 4'h0;
                scan_wrap = 1'b1;
            end else begin
                nxt_line = line_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            line_cnt_ff <= '0;
            line_ff <= 4'h0;
        end else begin
            line_cnt_ff <= nxt_line_cnt;
            line_ff <= nxt_line;
        end
    end

    // ==========================================================
    // Frame playback
    play_state_t state_ff, nxt_state;
    logic [5:0] frame_ff, nxt_frame;
    logic [5:0] pos_ff, nxt_pos;
    logic [2:0] done_ff, nxt_done;
    logic [TICK_W-1:0] tick_ff, nxt_tick;
    logic [3:0] ivl_cnt_ff, nxt_ivl_cnt;
    logic step_ff, nxt_step;
    logic advance;
    logic tick_end;
    logic last_loop;
    assign tick_end = (tick_ff == TICK_W'(FRAME_UNIT_CYCLES - 1));
    assign last_loop = (loops_f != LOOPS_ENDLESS) &&
        ((loops_f == LOOPS_INVALID) || ({1'b0, done_ff} + 4'h1 >= {1'b0, loops_f}));
    always_comb begin
        nxt_state = state_ff;
        nxt_frame = frame_ff;
        nxt_pos = pos_ff;
        nxt_done = done_ff;
        nxt_tick = tick_end ? '0 : tick_ff + 1'b1;
        nxt_ivl_cnt = tick_end ? ivl_cnt_ff + 1'b1 : ivl_cnt_ff;
        nxt_step = 1'b0;
        advance = 1'b0;
        if (ivl_f == 4'h0) begin
            advance = scan_wrap;
        end else begin
            advance = tick_end && (ivl_cnt_ff + 1'b1 >= ivl_f);
        end
        case (state_ff)
            ST_PLAY: begin
                if (!run_req) begin
                    nxt_state = still_req ? ST_STILL : ST_IDLE;
                    nxt_frame = still_frame;
                end else if (advance) begin
                    nxt_tick = '0;
                    nxt_ivl_cnt = 4'h0;
                    nxt_step = 1'b1;
                    if (pos_ff >= len_f) begin
                        if (last_loop) begin
                            nxt_state = ST_HALT;
                            if (scroll_en && !mode_ff[END_LAST_BIT]) begin
                                nxt_frame = start_frame;
                            end else begin
                                nxt_step = 1'b0;
                            end
                        end else begin
                            nxt_frame = start_frame;
                            nxt_pos = 6'h00;
                            nxt_done = (loops_f == LOOPS_ENDLESS) ? done_ff : done_ff + 1'b1;
                        end
                    end else begin
                        nxt_frame = frame_ff + 1'b1;
                        nxt_pos = pos_ff + 1'b1;
                    end
                end
            end
            ST_HALT: begin
                if (!run_req) begin
                    nxt_state = still_req ? ST_STILL : ST_IDLE;
                    nxt_frame = still_frame;
                end
            end
            default: begin
                if (run_req) begin
                    nxt_state = ST_PLAY;
                    nxt_frame = start_frame;
                    nxt_pos = 6'h00;
                    nxt_done = 3'h0;
                    nxt_tick = '0;
                    nxt_ivl_cnt = 4'h0;
                    nxt_step = 1'b1;
                end else begin
                    nxt_state = still_req ? ST_STILL : ST_IDLE;
                    nxt_frame = still_frame;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            frame_ff <= 6'h00;
            pos_ff <= 6'h00;
            done_ff <= 3'h0;
            tick_ff <= '0;
            ivl_cnt_ff <= 4'h0;
            step_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            frame_ff <= nxt_frame;
            pos_ff <= nxt_pos;
            done_ff <= nxt_done;
            tick_ff <= nxt_tick;
            ivl_cnt_ff <= nxt_ivl_cnt;
            step_ff <= nxt_step;
        end
    end

    // ==========================================================
    // Blink timebase and display flags
    logic [BLINK_W-1:0] blink_cnt_ff, nxt_blink_cnt;
    logic blink_ph_ff, nxt_blink_ph;
    logic [BLINK_W-1:0] blink_half;
    logic [7:0] flags_ff, nxt_flags;
    assign blink_half = option_ff[BLINK_PER_BIT] ? BLINK_W'(BLINK_LONG_HALF - 1) : BLINK_W'(BLINK_SHORT_HALF - 1);
    always_comb begin
        nxt_blink_cnt = blink_cnt_ff + 1'b1;
        nxt_blink_ph = blink_ph_ff;
        if (blink_cnt_ff >= blink_half) begin
            nxt_blink_cnt = '0;
            nxt_blink_ph = !blink_ph_ff;
        end
        nxt_flags[0] = (nxt_state == ST_PLAY);
        nxt_flags[1] = (nxt_state != ST_IDLE);
        nxt_flags[2] = !mode_ff[BLINK_OFF_BIT];
        nxt_flags[3] = nxt_blink_ph && !mode_ff[BLINK_OFF_BIT];
        nxt_flags[4] = timing_ff[FADE_BIT] && !timing_ff[BLOCK_BIT];
        nxt_flags[5] = scroll_en && (nxt_state == ST_PLAY);
        nxt_flags[6] = timing_ff[DIR_BIT];
        nxt_flags[7] = timing_ff[BLOCK_BIT];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            blink_cnt_ff <= '0;
            blink_ph_ff <= 1'b0;
            flags_ff <= 8'h00;
        end else begin
            blink_cnt_ff <= nxt_blink_cnt;
            blink_ph_ff <= nxt_blink_ph;
            flags_ff <= nxt_flags;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = rdata_ff;
    assign current_sink_line = line_ff;
    assign frame_index = frame_ff;
    assign frame_step = step_ff;
    assign playing = flags_ff[0];
    assign showing = flags_ff[1];
    assign blink_allowed = flags_ff[2];
    assign blink_on = flags_ff[3];
    assign fade_active = flags_ff[4];
    assign scroll_active = flags_ff[5];
    assign scroll_left = flags_ff[6];
    assign scroll_block = flags_ff[7];
endmodule
`default_nettype wire

// *** test/anim_seq_chk.sv ***
/* Port checker for the animation sequencer.
   Bound to the sequencer; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module anim_seq_chk (
    // Clock, reset and inputs
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run_req,
    input wire logic [5:0] start_frame,
    // Outputs
    input wire logic [3:0] current_sink_line,
    input wire logic [5:0] frame_index,
    input wire logic frame_step,
    input wire logic playing,
    input wire logic blink_on,
    input wire logic blink_allowed,
    input wire logic fade_active,
    input wire logic scroll_active,
    input wire logic scroll_block
);
    // ==========================================
    // Assertions
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    blink_gate_a: assert property (!blink_allowed |-> !blink_on)
        else $error("blink while disabled");
    fade_block_a: assert property (scroll_block |-> !fade_active)
        else $error("fade in block scroll");
    play_start_a: assert property ($rose(playing) |-> frame_index == $past(start_frame))
        else $error("wrong first frame");
    run_drop_a: assert property (!run_req |=> !playing)
        else $error("play without run request");
    frame_hold_a: assert property (playing && $past(playing) && $changed(frame_index) |-> frame_step)
        else $error("frame change without step");
    step_pulse_a: assert property (frame_step |=> !frame_step)
        else $error("step pulse too long");
    scroll_gate_a: assert property (scroll_active |-> playing)
        else $error("scroll while not playing");
    line_seq_a: assert property ($changed(current_sink_line) |->
        current_sink_line == 4'h0 || current_sink_line == $past(current_sink_line) + 4'h1)
        else $error("scan line out of order");
    line_hold_a: assert property ($changed(current_sink_line) |=> $stable(current_sink_line)[*8])
        else $error("scan line too short");
    line_range_a: assert property (current_sink_line <= 4'hB)
        else $error("scan line above last");
    cover property (frame_step && playing);
    cover property ($fell(playing));
    cover property (scroll_active && scroll_block);
endmodule
bind led_matrix_animation_sequencer anim_seq_chk u_chk (.core_clk, .rst_b, .run_req, .start_frame,
    .current_sink_line, .frame_index, .frame_step, .playing, .blink_on, .blink_allowed,
    .fade_active, .scroll_active, .scroll_block);
`default_nettype wire

// *** test/host_model.sv ***
/* Host side of the register strobe port: byte write and read tasks.
   Assumes the caller sits just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // ==========================================
    // Transfers; released lines show inverted data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/* Self-checking bench for the animation sequencer.
   Uses host_model for register access; short timing parameters. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_top;
    import anim_seq_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic run_req = 1'b0;
    logic still_req = 1'b0;
    logic [5:0] start_frame = 6'h05;
    logic [5:0] still_frame = 6'h09;
    logic reg_wr, reg_rd, frame_step, playing, showing, blink_on, blink_allowed;
    logic fade_active, scroll_active, scroll_left, scroll_block;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0] current_sink_line, m;
    logic [5:0] frame_index;
    int n_mismatch = 0;
    int checked = 0;
    int n;
    always #50 core_clk = ~core_clk;
    led_matrix_animation_sequencer #(.FRAME_UNIT_CYCLES(20), .BLINK_SHORT_HALF(30), .BLINK_LONG_HALF(60)) DUT (
        .core_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .run_req, .still_req,
        .start_frame, .still_frame, .current_sink_line, .frame_index, .frame_step, .playing, .showing,
        .blink_on, .blink_allowed, .fade_active, .scroll_active, .scroll_left, .scroll_block);
    host_model u_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    // ==========================================
    // Tasks
    task automatic results();
        $display("checked=%0d mismatches=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic prog(input logic [7:0] am, input logic [7:0] ft, input logic [7:0] dp);
        u_host.wr(ANIMATION_MODE_ADDR, am);
        u_host.wr(FRAME_TIMING_SCROLL_ADDR, ft);
        u_host.wr(DISPLAY_OPTIONS_ADDR, dp);
        run_req = 1'b1;
    endtask
    task automatic stop(input string s);
        run_req = 1'b0;
        cyc(2);
        $display("test %s done", s);
    endtask
    // Sel: 0 step, 1 stopped, 2 line change, 3 blink change
    task automatic wait_on(input int sel, output int k);
        logic [3:0] l0;
        logic b0;
        l0 = current_sink_line;
        b0 = blink_on;
        k = 0;
        forever begin
            @(posedge core_clk);
            #1;
            k++;
            if (sel == 0 && frame_step === 1'b1 || sel == 1 && playing === 1'b0 ||
                sel == 2 && current_sink_line !== l0 || sel == 3 && blink_on !== b0)
                break;
            if (k > 30000) begin
                n_mismatch++;
                results();
            end
        end
    endtask
    // ==========================================
    // Sequence
    initial begin
        cyc(4);
        rst_b = 1'b1;
        rdc(ANIMATION_MODE_ADDR, ANIMATION_MODE_RST);
        rdc(FRAME_TIMING_SCROLL_ADDR, FRAME_TIMING_SCROLL_RST);
        rdc(DISPLAY_OPTIONS_ADDR, DISPLAY_OPTIONS_RST);
        u_host.wr(8'h05, 8'hA5);
        rdc(8'h05, 8'h00);
        u_host.wr(FRAME_TIMING_SCROLL_ADDR, 8'h5A);
        rdc(FRAME_TIMING_SCROLL_ADDR, 8'h5A);
        $display("test regs done");
        prog(8'h01, 8'h01, 8'h2B);
        wait_on(0, n);
        `CHK(frame_index, 6'h05)
        wait_on(0, n);
        `CHK(n, 20)
        `CHK(frame_index, 6'h06)
        wait_on(1, n);
        `CHK(frame_index, 6'h06)
        stop("play");
        prog(8'h02, 8'h02, 8'h4B);
        for (int i = 0; i < 6; i++) begin
            wait_on(0, n);
            `CHK(frame_index, 6'(5 + i % 3))
            if (i > 0) `CHK(n, 40)
        end
        wait_on(1, n);
        `CHK(n <= 41, 1'b1)
        stop("loops");
        start_frame = 6'h00;
        prog(8'h3F, 8'h01, 8'h2B);
        repeat (36) wait_on(0, n);
        `CHK(frame_index, 6'h23)
        wait_on(1, n);
        `CHK(n <= 21, 1'b1)
        start_frame = 6'h05;
        stop("clamp");
        prog(8'h00, 8'h01, 8'hEB);
        repeat (10) wait_on(0, n);
        `CHK(playing, 1'b1)
        u_host.wr(DISPLAY_OPTIONS_ADDR, 8'h2B);
        wait_on(1, n);
        `CHK(n <= 200, 1'b1)
        stop("endless");
        for (int e = 0; e < 2; e++) begin
            prog({1'b0, e[0], 6'h01}, 8'hB1, 8'h2B);
            wait_on(0, n);
            `CHK(scroll_active, 1'b1)
            `CHK(scroll_block, 1'b1)
            `CHK(scroll_left, 1'b0)
            `CHK(fade_active, 1'b0)
            wait_on(1, n);
            `CHK(frame_index, 6'(5 + e))
            stop("scroll");
        end
        u_host.wr(FRAME_TIMING_SCROLL_ADDR, 8'hD1);
        cyc(2);
        `CHK(fade_active, 1'b1)
        `CHK(scroll_left, 1'b1)
        `CHK(scroll_block, 1'b0)
        `CHK(scroll_active, 1'b0)
        u_host.wr(ANIMATION_MODE_ADDR, 8'h80);
        cyc(2);
        `CHK(blink_allowed, 1'b0)
        `CHK(blink_on, 1'b0)
        u_host.wr(ANIMATION_MODE_ADDR, 8'h00);
        for (int f = 0; f < 2; f++) begin
            u_host.wr(DISPLAY_OPTIONS_ADDR, {3'h1, f[0], 4'hB});
            wait_on(3, n);
            wait_on(3, n);
            `CHK(n, 30 + 30 * f)
        end
        $display("test blink done");
        still_req = 1'b1;
        cyc(2);
        `CHK(showing, 1'b1)
        `CHK(playing, 1'b0)
        `CHK(frame_index, 6'h09)
        run_req = 1'b1;
        cyc(2);
        `CHK(playing, 1'b1)
        `CHK(frame_index, 6'h05)
        stop("still");
        `CHK(frame_index, 6'h09)
        still_req = 1'b0;
        u_host.wr(DISPLAY_OPTIONS_ADDR, 8'h22);
        m = 4'h0;
        for (int i = 0; i < 6; i++) begin
            wait_on(2, n);
            if (i > 0) `CHK(n, LINE_CYC)
            if (i > 0 && current_sink_line > m) m = current_sink_line;
        end
        `CHK(m, 4'h2)
        prog(8'h01, 8'h00, 8'h20);
        wait_on(0, n);
        wait_on(0, n);
        `CHK(n <= LINE_CYC + 1, 1'b1)
        stop("scan");
        run_req = 1'b1;
        cyc(3);
        rst_b = 1'b0;
        cyc(1);
        rst_b = 1'b1;
        `CHK(playing, 1'b0)
        `CHK(current_sink_line, 4'h0)
        cyc(1);
        `CHK(frame_index, 6'h05)
        `CHK(playing, 1'b1)
        rdc(ANIMATION_MODE_ADDR, ANIMATION_MODE_RST);
        rdc(DISPLAY_OPTIONS_ADDR, DISPLAY_OPTIONS_RST);
        stop("reset");
        results();
    end
endmodule
`default_nettype wire
